// [rtl/bsc_array.sv]
// Storage array with a synchronous write port and a registered read port
`timescale 1ns/1ps
module bsc_array #(
    parameter int ADDR_W = bsc_pkg::ADDR_W,
    parameter int DATA_W = bsc_pkg::DATA_W,
    parameter int DEPTH = bsc_pkg::DEPTH
) (
    input wire logic clk_sys,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [DATA_W-1:0] wr_data,
    input wire logic rd_en,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem [DEPTH];

    // No reset: array content is undefined until written, as in the real part
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read holds its word when not enabled, so a paused burst keeps its output
    always_ff @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// [rtl/bsc_pkg.sv]
// Package of constants and carrier types for the burst cache SRAM control block
package bsc_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 9;
    localparam int DEPTH = 32768;
    localparam int BURST_BITS = 2;
    localparam logic [1:0] BURST_LAST = 2'h3;
    localparam logic [1:0] BURST_FIRST = 2'h0;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 9'h000;

    // Pin bundle sampled on each rising edge; all controls are active low
    typedef struct packed {
        logic address_launch_n;
        logic chip_select_n;
        logic write_enable_n;
        logic output_enable_n;
        logic [ADDR_W-1:0] word_address;
    } bsc_ctrl_t;

    // Registered write request captured one edge after the address
    typedef struct packed {
        logic valid;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } bsc_wreq_t;
endpackage

// [rtl/bsc_top.sv]
// Burst counter, self-timed write and output control of the cache SRAM
`timescale 1ns/1ps
// What this block does
// - First edge with launch strobe low loads the external address as burst start.
// - Data and write enable are registered on the edge after address capture.
// - Registered write stores registered data at registered address that same cycle.
// - Counter advances only on edges where chip select is sampled low.
// - Chip select high without a launch holds the counter at its present value.
// - Write happens only when chip select and write enable are both sampled low.
// - A new launch strobe mid-burst abandons it and restarts from the new address.
// - With counting paused, the same output word stays while output enable is low.
// - Counter touches two low bits only: s, s^1, s^2, s^3.
// - Burst write words go to start, bit0 flipped, bit1 flipped, both flipped.
// - Address pins ignored after first cycle; reload needs strobe high on prior edge.
// - Start address reads the array next cycle; three more words follow.
// - After the fourth count the counter wraps to start and repeats.
module bsc_top #(
    parameter int ADDR_W = bsc_pkg::ADDR_W,
    parameter int DATA_W = bsc_pkg::DATA_W,
    parameter int DEPTH = bsc_pkg::DEPTH
) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic address_launch_n,
    input wire logic chip_select_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic [DATA_W-1:0] data_pins_in,
    output logic [DATA_W-1:0] data_pins_out,
    output logic data_pins_oe,
    output logic [ADDR_W-1:0] burst_address,
    output logic burst_active
);
    ////////////////////////////////////////////////////////////////////////
    typedef enum logic {
        BSC_IDLE,
        BSC_BURST
    } bsc_state_t;

    bsc_pkg::bsc_ctrl_t pins;
    bsc_pkg::bsc_wreq_t wreq_q;
    bsc_state_t state_q;
    logic launch_prev_n_q;
    logic [ADDR_W-1:0] start_q;
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic launch;
    logic [ADDR_W-1:0] cur_addr;
    logic [DATA_W-1:0] rd_word;
    logic rd_en;

    // Offset s xor n over the two low address bits
    function automatic logic [ADDR_W-1:0] bsc_burst_addr(input logic [ADDR_W-1:0] s,
                                                        input logic [1:0] n);
        bsc_burst_addr = {s[ADDR_W-1:2], s[1:0] ^ n};
    endfunction

    assign pins = '{address_launch_n, chip_select_n, write_enable_n, output_enable_n,
                    word_address};

    ////////////////////////////////////////////////////////////////////////
    // Address launch: a held-low strobe is one launch only
    assign launch = !pins.address_launch_n && launch_prev_n_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            launch_prev_n_q <= 1'b1;
        end else begin
            launch_prev_n_q <= pins.address_launch_n;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            start_q <= bsc_pkg::ADDR_RST;
        end else if (launch) begin
            start_q <= pins.word_address;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Burst counter
    always_comb begin
        count_d = count_q;
        if (launch) begin
            count_d = bsc_pkg::BURST_FIRST;
        end else if (state_q == BSC_BURST && !pins.chip_select_n) begin
            count_d = count_q + 2'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            count_q <= bsc_pkg::BURST_FIRST;
        end else begin
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_q <= BSC_IDLE;
        end else begin
            case (state_q)
                BSC_IDLE: begin
                    if (launch) begin
                        state_q <= BSC_BURST;
                    end
                end
                BSC_BURST: begin
                    state_q <= BSC_BURST;
                end
                default: begin
                    state_q <= BSC_IDLE;
                end
            endcase
        end
    end

    // Address the current count points at, valid from the cycle after launch
    assign cur_addr = bsc_burst_addr(start_q, count_q);

    ////////////////////////////////////////////////////////////////////////
    // Self-timed write: data and enable land one edge after the address
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            wreq_q <= '{1'b0, bsc_pkg::ADDR_RST, bsc_pkg::DATA_RST};
        end else begin
            wreq_q.valid <= state_q == BSC_BURST && !launch
                            && !pins.chip_select_n && !pins.write_enable_n;
            wreq_q.addr <= cur_addr;
            wreq_q.data <= data_pins_in;
        end
    end

    // Read the current word; stall the read with the counter so output holds
    assign rd_en = launch || !pins.chip_select_n || state_q == BSC_IDLE;

    bsc_array #(
        .ADDR_W(ADDR_W),
        .DATA_W(DATA_W),
        .DEPTH(DEPTH)
    ) u_array (
        .clk_sys(clk_sys),
        .wr_en(wreq_q.valid),
        .wr_addr(wreq_q.addr),
        .wr_data(wreq_q.data),
        .rd_en(rd_en),
        .rd_addr(launch ? pins.word_address : count_d == count_q ? cur_addr
                 : bsc_burst_addr(start_q, count_d)),
        .rd_data(rd_word)
    );

    ////////////////////////////////////////////////////////////////////////
    // Outputs registered; enable follows the pins one edge late, as inputs are synchronous
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            data_pins_oe <= 1'b0;
            data_pins_out <= bsc_pkg::DATA_RST;
            burst_address <= bsc_pkg::ADDR_RST;
            burst_active <= 1'b0;
        end else begin
            data_pins_oe <= !pins.output_enable_n && pins.write_enable_n;
            data_pins_out <= wreq_q.valid && wreq_q.addr == cur_addr ? wreq_q.data
                             : rd_word;
            burst_address <= cur_addr;
            burst_active <= state_q == BSC_BURST;
        end
    end
endmodule

// [testbench/bsc_bus_partner.sv]
// Far-side controller model driving the shared data wire
`timescale 1ns/1ps
module bsc_bus_partner (
    input wire logic clk_sys,
    input wire logic drive,
    input wire logic [8:0] wdata,
    input wire logic dev_oe,
    input wire logic [8:0] dev_data,
    output logic [8:0] wire_val
);
    logic [8:0] last_q = 9'h000;
    // A floating wire shows the inverse of its last value, so stale data cannot pass
    always_comb begin
        if (drive) wire_val = wdata;
        else if (dev_oe) wire_val = dev_data;
        else wire_val = ~last_q;
    end
    always_ff @(posedge clk_sys) last_q <= wire_val;
endmodule

// [testbench/bsc_top_monitor.sv]
// Checker for the burst cache SRAM control block
`timescale 1ns/1ps
module bsc_top_monitor #(parameter int ADDR_W = 15, parameter int DATA_W = 9) (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic address_launch_n,
    input wire logic chip_select_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic [DATA_W-1:0] data_pins_out,
    input wire logic data_pins_oe,
    input wire logic [ADDR_W-1:0] burst_address,
    input wire logic burst_active
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic prev_q;
    logic [ADDR_W-1:0] ba_q;
    wire launch = !address_launch_n && prev_q;
    // Starts high so the first strobe after reset counts as a launch
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) prev_q <= 1'h1;
        else prev_q <= address_launch_n;
    end
    always_ff @(posedge clk_sys) ba_q <= burst_address;
    sequence run;
        !chip_select_n && !launch;
    endsequence
    // The address output is registered from a combinational address, so it trails by two edges
    a_launch_load: assert property (
        launch |-> ##2 burst_address == $past(word_address, 2) && burst_active)
        else $error("start address not loaded");
    a_step_two: assert property (
        launch ##1 run [*2] |-> ##2 burst_address == ($past(burst_address, 2) ^ 15'h0002))
        else $error("third burst word not start with bit 1 flipped");
    a_wrap_four: assert property (
        launch ##1 run [*4] |-> ##2 burst_address == $past(burst_address, 4))
        else $error("counter did not wrap to start");
    a_count_hold: assert property (
        chip_select_n && !launch |-> ##2 burst_address == ba_q)
        else $error("counter moved while paused");
    a_count_move: assert property (
        run and burst_active |-> ##2 burst_address[ADDR_W-1:2] == ba_q[ADDR_W-1:2]
            && burst_address[1:0] != ba_q[1:0])
        else $error("counter step wrong");
    a_oe_float: assert property (output_enable_n |=> !data_pins_oe)
        else $error("data pins driven while disabled");
    a_oe_drive: assert property (!output_enable_n && write_enable_n && burst_active |=> data_pins_oe)
        else $error("data pins not driven for read");
    a_read_hold: assert property (
        (chip_select_n && !launch && !output_enable_n) [*3] |=> $stable(data_pins_out))
        else $error("output word changed while paused");
endmodule
bind bsc_top bsc_top_monitor #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_mon (.*);

// [testbench/burst_sram_control_tb_top.sv]
// Self-checking bench for the burst cache SRAM control block
`timescale 1ns/1ps
module burst_sram_control_tb_top;
    localparam logic [14:0] A = 15'h02A1;
    logic clk_sys = 1'h0, reset = 1'h1, aln_n = 1'h1, cs_n = 1'h1;
    logic we_n = 1'h1, oe_n = 1'h1, drv = 1'h0, oe, act;
    logic [14:0] addr = 15'h0000, ba;
    logic [8:0] wd = 9'h000, bus, dout;
    logic [8:0] d [4] = '{9'h1C3, 9'h0E5, 9'h12A, 9'h07F};
    int miscompares = 0, checks = 0;
    bsc_top i_dut (.clk_sys(clk_sys), .reset(reset), .address_launch_n(aln_n),
        .chip_select_n(cs_n), .write_enable_n(we_n), .output_enable_n(oe_n),
        .word_address(addr), .data_pins_in(bus), .data_pins_out(dout),
        .data_pins_oe(oe), .burst_address(ba), .burst_active(act));
    bsc_bus_partner i_ctl (.clk_sys(clk_sys), .drive(drv), .wdata(wd),
        .dev_oe(oe), .dev_data(dout), .wire_val(bus));
    initial forever #12.5 clk_sys = ~clk_sys;
    ////////////////////////////////////////
    task automatic chk(input string n, input logic [14:0] e, input logic [14:0] s);
        checks++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic launch(input logic [14:0] a, input logic w, input logic o);
        @(posedge clk_sys) #2;
        aln_n = 1'h0;
        addr = a;
        cs_n = 1'h0;
        we_n = w;
        oe_n = o;
        drv = 1'h0;
    endtask
    task automatic wr(input logic [8:0] v, input logic c, input logic w);
        @(posedge clk_sys) #2;
        aln_n = 1'h1;
        cs_n = c;
        we_n = w;
        drv = 1'h1;
        wd = v;
    endtask
    ////////////////////////////////////////
    task automatic test_write();
        launch(A, 1'h1, 1'h1);
        wr(d[0], 1'h0, 1'h0);
        wr(9'h1AA, 1'h1, 1'h0);
        // The address output trails the counter by one registered stage
        chk("start", A, ba);
        chk("active", 15'h0001, act);
        wr(d[1], 1'h0, 1'h0);
        chk("step", A ^ 15'h0001, ba);
        wr(d[2], 1'h0, 1'h0);
        chk("pause", A ^ 15'h0001, ba);
        wr(d[3], 1'h0, 1'h0);
        // Relaunch mid-burst, then two late aborts both aimed at the written word A ^ 3
        launch(A ^ 15'h0002, 1'h1, 1'h1);
        wr(9'h1FF, 1'h0, 1'h1);
        wr(9'h0AB, 1'h1, 1'h0);
        chk("relaunch", A ^ 15'h0002, ba);
        wr(9'h0AB, 1'h1, 1'h0);
        chk("abort step", A ^ 15'h0003, ba);
        $display("write test done");
    endtask
    task automatic test_read();
        launch(A ^ 15'h0003, 1'h1, 1'h0);
        for (int i = 1; i < 9; i++) begin
            @(posedge clk_sys) #2;
            if (i >= 2) chk("word", d[i < 6 ? (i - 2) ^ 3 : 3], dout);
            aln_n = (i != 1);
            addr = ~addr;
            cs_n = (i >= 5);
        end
        chk("drive", 15'h0001, oe);
        oe_n = 1'h1;
        @(posedge clk_sys) #2;
        chk("float", 15'h0000, oe);
        $display("read test done");
    endtask
    task automatic finish_test();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (5) @(posedge clk_sys);
        #2;
        reset = 1'h0;
        test_write();
        test_read();
        finish_test();
    end
    // The run needs about 25 cycles; 200 leaves room without hiding a hang
    initial begin
        #(25 * 200);
        miscompares++;
        finish_test();
    end
endmodule
